//--- dv/eifl_irq_source.sv
// partner: external interrupt pins and cpu vectoring pulses
`timescale 1ns/1ps
module eifl_irq_source (
   input wire logic i_clk,
   output logic o_pin_a,
   output logic o_pin_b,
   output logic o_ack_a,
   output logic o_ack_b
);
   initial begin
      o_pin_a = 1'b1;
      o_pin_b = 1'b1;
      o_ack_a = 1'b0;
      o_ack_b = 1'b0;
   end
   task automatic pins(input logic a, input logic b);
      @(posedge i_clk);
      o_pin_a <= a;
      o_pin_b <= b;
   endtask : pins
   // vectoring is a one-cycle pulse
   task automatic vector(input logic a, input logic b);
      @(posedge i_clk);
      o_ack_a <= a;
      o_ack_b <= b;
      @(posedge i_clk);
      o_ack_a <= 1'b0;
      o_ack_b <= 1'b0;
   endtask : vector
endmodule : eifl_irq_source

//--- dv/eifl_top_assertions.sv
// checker: port-level assertions for the external interrupt flag logic
`timescale 1ns/1ps
module eifl_top_assertions (
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   input wire logic I_EXT_IRQ_A_INPUT,
   input wire logic I_VECTOR_A_ACK,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] O_RDATA,
   input wire logic O_EXT_IRQ_A_PENDING,
   input wire logic O_IRQ
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);
   logic type_a_reg;
   logic pol_a_reg;
   logic [1:0] mask_reg;
   logic clr_a;
   assign clr_a = I_WR && I_ADDR == eifl_pkg::CTRL_OFF && !I_WDATA[eifl_pkg::PEND_A_BIT];
   // shadow of the configuration that the assertions depend on
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         type_a_reg <= 1'b0;
         pol_a_reg <= 1'b0;
         mask_reg <= 2'h0;
      end else if (I_WR) begin
         if (I_ADDR == eifl_pkg::CTRL_OFF) begin
            type_a_reg <= I_WDATA[eifl_pkg::TYPE_A_BIT];
         end
         if (I_ADDR == eifl_pkg::POL_OFF) begin
            pol_a_reg <= I_WDATA[eifl_pkg::POL_A_BIT];
         end
         if (I_ADDR == eifl_pkg::MASK_OFF) begin
            mask_reg <= {I_WDATA[eifl_pkg::EV_B_BIT], I_WDATA[eifl_pkg::EV_A_BIT]};
         end
      end
   end
   chk_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data not zero outside a read");
   chk_rdata_upper: assert property ($past(I_RD) |-> O_RDATA[7:4] == 4'h0)
      else $error("unused read bits not zero");
   chk_pend_fall: assert property ($fell(O_EXT_IRQ_A_PENDING) |->
      $past(I_VECTOR_A_ACK, 2) || $past(clr_a, 2)) else $error("pending fell without a cause");
   chk_level_set: assert property ((!type_a_reg && I_EXT_IRQ_A_INPUT == pol_a_reg)[*4]
      |=> ##1 O_EXT_IRQ_A_PENDING) else $error("active level did not set pending");
   chk_edge_ack: assert property ($stable(I_EXT_IRQ_A_INPUT)[*4] ##0
      (I_VECTOR_A_ACK && type_a_reg) |=> ##1 !O_EXT_IRQ_A_PENDING) else $error("no clear on ack");
   chk_edge_quiet: assert property ((type_a_reg && $stable(I_EXT_IRQ_A_INPUT))[*6]
      |-> !$rose(O_EXT_IRQ_A_PENDING)) else $error("pending set without an edge");
   chk_irq_masked: assert property (mask_reg == 2'h0 && $past(mask_reg) == 2'h0 |-> !O_IRQ)
      else $error("interrupt high while fully masked");
   chk_irq_cause: assert property ($rose(O_IRQ) |-> $past(mask_reg) != 2'h0)
      else $error("interrupt rose with mask clear");
endmodule : eifl_top_assertions
bind eifl_top eifl_top_assertions u_chk (.*);

//--- dv/tb.sv
// testbench: registers, edge, level and polarity behaviour of the flag logic
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
   logic I_REF_CLK = 1'b0;
   logic I_RST_B = 1'b0;
   wire logic I_EXT_IRQ_A_INPUT;
   wire logic I_EXT_IRQ_B_INPUT;
   wire logic I_VECTOR_A_ACK;
   wire logic I_VECTOR_B_ACK;
   logic [3:0] I_ADDR = 4'h0;
   logic [7:0] I_WDATA = 8'h00;
   logic I_WR = 1'b0;
   logic I_RD = 1'b0;
   logic [7:0] O_RDATA;
   logic O_EXT_IRQ_A_PENDING;
   logic O_EXT_IRQ_B_PENDING;
   logic O_IRQ;
   logic [7:0] d;
   int failures = 0;
   int n_tests = 0;
   // address, write data, read-back
   logic [19:0] rows [7] = '{20'h0FF05, 20'h00000, 20'h3FF03, 20'h30000, 20'h7FF00,
      20'h1FF03, 20'h10000};
   eifl_top u_eifl_top (.*);
   eifl_irq_source u_eifl_irq_source (.i_clk(I_REF_CLK), .o_pin_a(I_EXT_IRQ_A_INPUT),
      .o_pin_b(I_EXT_IRQ_B_INPUT), .o_ack_a(I_VECTOR_A_ACK), .o_ack_b(I_VECTOR_B_ACK));
   initial begin
      forever #12.5 I_REF_CLK = ~I_REF_CLK;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge I_REF_CLK);
      #1;
   endtask : wt
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge I_REF_CLK);
      I_WR <= 1'b1;
      I_ADDR <= a;
      I_WDATA <= v;
      @(posedge I_REF_CLK);
      I_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge I_REF_CLK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      @(posedge I_REF_CLK);
      I_RD <= 1'b0;
      #1;
      d = O_RDATA;
   endtask : rd
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   initial begin
      wt(3000);
      failures++;
      final_report();
   end
   initial begin
      wt(5);
      I_RST_B <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i][19:16], rows[i][15:8]);
         rd(rows[i][19:16]);
         `CHK(d, rows[i][7:0])
      end
      $display("test registers done");
      wr(eifl_pkg::CTRL_OFF, 8'h05);
      wr(eifl_pkg::STAT_OFF, 8'h03);
      wr(eifl_pkg::MASK_OFF, 8'h03);
      u_eifl_irq_source.pins(1'b0, 1'b1);
      wt(6);
      `CHK({O_EXT_IRQ_A_PENDING, O_EXT_IRQ_B_PENDING, O_IRQ}, 3'h5)
      rd(eifl_pkg::STAT_OFF);
      `CHK(d, 8'h01)
      u_eifl_irq_source.vector(1'b1, 1'b0);
      wt(2);
      `CHK(O_EXT_IRQ_A_PENDING, 1'b0)
      wr(eifl_pkg::STAT_OFF, 8'h01);
      wt(2);
      `CHK(O_IRQ, 1'b0)
      $display("test edge done");
      wr(eifl_pkg::CTRL_OFF, 8'h04);
      wt(3);
      `CHK(O_EXT_IRQ_A_PENDING, 1'b1)
      u_eifl_irq_source.vector(1'b1, 1'b0);
      wt(2);
      `CHK(O_EXT_IRQ_A_PENDING, 1'b1)
      u_eifl_irq_source.pins(1'b1, 1'b1);
      wt(4);
      wr(eifl_pkg::CTRL_OFF, 8'h04);
      wt(2);
      `CHK(O_EXT_IRQ_A_PENDING, 1'b0)
      $display("test level done");
      wr(eifl_pkg::POL_OFF, 8'h02);
      wt(4);
      wr(eifl_pkg::CTRL_OFF, 8'h04);
      u_eifl_irq_source.pins(1'b1, 1'b0);
      wt(6);
      `CHK(O_EXT_IRQ_B_PENDING, 1'b0)
      u_eifl_irq_source.pins(1'b1, 1'b1);
      wt(6);
      `CHK(O_EXT_IRQ_B_PENDING, 1'b1)
      wr(eifl_pkg::MASK_OFF, 8'h00);
      wt(2);
      `CHK(O_IRQ, 1'b0)
      wr(eifl_pkg::MASK_OFF, 8'h02);
      wt(2);
      `CHK(O_IRQ, 1'b1)
      u_eifl_irq_source.vector(1'b0, 1'b1);
      wt(2);
      `CHK(O_EXT_IRQ_B_PENDING, 1'b0)
      $display("test polarity done");
      I_RST_B <= 1'b0;
      wt(2);
      `CHK({O_EXT_IRQ_A_PENDING, O_EXT_IRQ_B_PENDING, O_IRQ, O_RDATA}, 11'h000)
      I_RST_B <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         rd(k[3:0]);
         `CHK(d, eifl_pkg::ZERO_BYTE)
      end
      $display("test reset done");
      final_report();
   end
endmodule : tb

//--- shared/eifl_pkg.sv
// package: register map, field positions and types for external interrupt flag logic
package eifl_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [3:0] CTRL_OFF = 4'h0;
   localparam logic [3:0] POL_OFF = 4'h1;
   localparam logic [3:0] STAT_OFF = 4'h2;
   localparam logic [3:0] MASK_OFF = 4'h3;
   // control register field positions
   localparam int TYPE_A_BIT = 0;
   localparam int PEND_A_BIT = 1;
   localparam int TYPE_B_BIT = 2;
   localparam int PEND_B_BIT = 3;
   // polarity register field positions
   localparam int POL_A_BIT = 0;
   localparam int POL_B_BIT = 1;
   // status and mask register field positions
   localparam int EV_A_BIT = 0;
   localparam int EV_B_BIT = 1;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] POL_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic TYPE_EDGE = 1'b1;
   localparam logic TYPE_LEVEL = 1'b0;
endpackage : eifl_pkg

//--- src/eifl_channel.sv
// one external interrupt input: synchroniser, edge/level detection and pending flag
`timescale 1ns/1ps
module eifl_channel (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_pin,
   input wire logic i_polarity,
   input wire logic i_type_select,
   input wire logic i_sw_clear,
   input wire logic i_vector_ack,
   output logic o_pending,
   output logic o_event
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   logic active;
   logic prev_active;
   logic detect;
   logic pending_next;

   // two-stage synchroniser, then one more stage for edge compare
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         // idle level of an active-low pin, so leaving reset raises no false event
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         sync1_reg <= i_pin;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // polarity 1 means active high
   assign active = ~(sync2_reg ^ i_polarity);
   assign prev_active = ~(prev_reg ^ i_polarity);
   assign detect = (i_type_select == eifl_pkg::TYPE_EDGE) ?
      (active & ~prev_active) : active;

   // a detection in the same cycle as a clear wins
   always_comb begin
      pending_next = o_pending;
      if (i_sw_clear) begin
         pending_next = 1'b0;
      end
      if (i_vector_ack && i_type_select == eifl_pkg::TYPE_EDGE) begin
         pending_next = 1'b0;
      end
      if (detect) begin
         pending_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pending <= 1'b0;
         o_event <= 1'b0;
      end else begin
         o_pending <= pending_next;
         o_event <= detect & ~o_pending;
      end
   end
endmodule : eifl_channel

//--- src/eifl_top.sv
// external interrupt flag logic: register port, two channels, status/mask interrupt
`timescale 1ns/1ps
module eifl_top (
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   input wire logic I_EXT_IRQ_A_INPUT,
   input wire logic I_EXT_IRQ_B_INPUT,
   input wire logic I_VECTOR_A_ACK,
   input wire logic I_VECTOR_B_ACK,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   output logic O_EXT_IRQ_A_PENDING,
   output logic O_EXT_IRQ_B_PENDING,
   output logic O_IRQ
);
   logic ext_irq_a_type_select_reg;
   logic ext_irq_b_type_select_reg;
   logic ext_irq_a_polarity_reg;
   logic ext_irq_b_polarity_reg;
   logic [7:0] mask_reg;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [7:0] rdata_next;
   logic ext_irq_a_pending;
   logic ext_irq_b_pending;
   logic ev_a;
   logic ev_b;
   logic clr_a;
   logic clr_b;
   logic wr_ctrl;
   logic wr_pol;
   logic wr_stat;
   logic wr_mask;

   function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
      hit = (addr == off);
   endfunction : hit

   assign wr_ctrl = I_WR & hit(I_ADDR, eifl_pkg::CTRL_OFF);
   assign wr_pol = I_WR & hit(I_ADDR, eifl_pkg::POL_OFF);
   assign wr_stat = I_WR & hit(I_ADDR, eifl_pkg::STAT_OFF);
   assign wr_mask = I_WR & hit(I_ADDR, eifl_pkg::MASK_OFF);
   // writing zero to a pending bit clears it; writing one leaves it
   assign clr_a = wr_ctrl & ~I_WDATA[eifl_pkg::PEND_A_BIT];
   assign clr_b = wr_ctrl & ~I_WDATA[eifl_pkg::PEND_B_BIT];

   // type-select bits
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ext_irq_a_type_select_reg <= eifl_pkg::CTRL_RST[eifl_pkg::TYPE_A_BIT];
         ext_irq_b_type_select_reg <= eifl_pkg::CTRL_RST[eifl_pkg::TYPE_B_BIT];
      end else if (wr_ctrl) begin
         ext_irq_a_type_select_reg <= I_WDATA[eifl_pkg::TYPE_A_BIT];
         ext_irq_b_type_select_reg <= I_WDATA[eifl_pkg::TYPE_B_BIT];
      end
   end

   // polarity configuration bits, 1 = active high
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ext_irq_a_polarity_reg <= eifl_pkg::POL_RST[eifl_pkg::POL_A_BIT];
         ext_irq_b_polarity_reg <= eifl_pkg::POL_RST[eifl_pkg::POL_B_BIT];
      end else if (wr_pol) begin
         ext_irq_a_polarity_reg <= I_WDATA[eifl_pkg::POL_A_BIT];
         ext_irq_b_polarity_reg <= I_WDATA[eifl_pkg::POL_B_BIT];
      end
   end

   eifl_channel u_chan_a (
      .i_clk(I_REF_CLK),
      .i_rst_b(I_RST_B),
      .i_pin(I_EXT_IRQ_A_INPUT),
      .i_polarity(ext_irq_a_polarity_reg),
      .i_type_select(ext_irq_a_type_select_reg),
      .i_sw_clear(clr_a),
      .i_vector_ack(I_VECTOR_A_ACK),
      .o_pending(ext_irq_a_pending),
      .o_event(ev_a)
   );

   eifl_channel u_chan_b (
      .i_clk(I_REF_CLK),
      .i_rst_b(I_RST_B),
      .i_pin(I_EXT_IRQ_B_INPUT),
      .i_polarity(ext_irq_b_polarity_reg),
      .i_type_select(ext_irq_b_type_select_reg),
      .i_sw_clear(clr_b),
      .i_vector_ack(I_VECTOR_B_ACK),
      .o_pending(ext_irq_b_pending),
      .o_event(ev_b)
   );

   // sticky status, write one to clear, a new event wins over the clear
   always_comb begin
      status_next = status_reg;
      if (wr_stat) begin
         status_next = status_reg & ~I_WDATA;
      end
      if (ev_a) begin
         status_next[eifl_pkg::EV_A_BIT] = 1'b1;
      end
      if (ev_b) begin
         status_next[eifl_pkg::EV_B_BIT] = 1'b1;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         status_reg <= eifl_pkg::ZERO_BYTE;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         mask_reg <= eifl_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_reg <= I_WDATA;
      end
   end

   // read mux, unused bits read as zero, unmapped addresses read zero
   always_comb begin
      rdata_next = eifl_pkg::ZERO_BYTE;
      if (I_RD) begin
         unique case (I_ADDR)
            eifl_pkg::CTRL_OFF: begin
               rdata_next[eifl_pkg::TYPE_A_BIT] = ext_irq_a_type_select_reg;
               rdata_next[eifl_pkg::PEND_A_BIT] = ext_irq_a_pending;
               rdata_next[eifl_pkg::TYPE_B_BIT] = ext_irq_b_type_select_reg;
               rdata_next[eifl_pkg::PEND_B_BIT] = ext_irq_b_pending;
            end
            eifl_pkg::POL_OFF: begin
               rdata_next[eifl_pkg::POL_A_BIT] = ext_irq_a_polarity_reg;
               rdata_next[eifl_pkg::POL_B_BIT] = ext_irq_b_polarity_reg;
            end
            eifl_pkg::STAT_OFF: begin
               rdata_next = status_reg;
            end
            eifl_pkg::MASK_OFF: begin
               rdata_next[eifl_pkg::EV_A_BIT] = mask_reg[eifl_pkg::EV_A_BIT];
               rdata_next[eifl_pkg::EV_B_BIT] = mask_reg[eifl_pkg::EV_B_BIT];
            end
            default: begin
               rdata_next = eifl_pkg::ZERO_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA <= eifl_pkg::ZERO_BYTE;
         O_EXT_IRQ_A_PENDING <= 1'b0;
         O_EXT_IRQ_B_PENDING <= 1'b0;
         O_IRQ <= 1'b0;
      end else begin
         O_RDATA <= rdata_next;
         O_EXT_IRQ_A_PENDING <= pending_a_out(ext_irq_a_pending);
         O_EXT_IRQ_B_PENDING <= pending_a_out(ext_irq_b_pending);
         O_IRQ <= |(status_next & mask_reg);
      end
   end

   function automatic logic pending_a_out(input logic p);
      pending_a_out = p;
   endfunction : pending_a_out
endmodule : eifl_top
